/* File: hw/spih_pkg.sv */
package spih_pkg;

    // register byte offsets from the chip-select base
    localparam logic [4:0] SPIH_OFF_CFG = 5'h00;
    localparam logic [4:0] SPIH_OFF_RSVD = 5'h04;
    localparam logic [4:0] SPIH_OFF_PREAMBLE = 5'h08;
    localparam logic [4:0] SPIH_OFF_XFER = 5'h0C;
    localparam logic [4:0] SPIH_OFF_FLAGS = 5'h10;
    localparam logic [4:0] SPIH_OFF_SELECT = 5'h14;
    localparam logic [4:0] SPIH_OFF_TXPORT = 5'h18;
    localparam logic [4:0] SPIH_OFF_RXPORT = 5'h1C;

    // serial_control_primary (byte 0)
    localparam int SPIH_CR1_LOW_BIT_FIRST = 0;
    localparam int SPIH_CR1_PHASE = 2;
    localparam int SPIH_CR1_POLARITY = 3;
    localparam int SPIH_CR1_MASTER_ROLE = 4;
    localparam int SPIH_CR1_PORT_ENABLE = 6;
    localparam int SPIH_CR1_IRQ_ENABLE = 7;
    localparam logic [7:0] SPIH_CR1_MASK = 8'hDD;
    localparam logic [7:0] SPIH_CR1_RESET = 8'h04;
    // serial_control_secondary (byte 1)
    localparam int SPIH_CR2_PIN_CONFIG = 0;
    localparam int SPIH_CR2_SHARED_OE = 2;
    localparam logic [7:0] SPIH_CR2_MASK = 8'h05;
    localparam logic [7:0] SPIH_CR2_RESET = 8'h00;
    // clock_divider_setting (byte 2): power in [2:0], prescale in [6:4]
    localparam logic [7:0] SPIH_BR_MASK = 8'h77;
    localparam logic [7:0] SPIH_BR_RESET = 8'h00;
    localparam int SPIH_BR_POWER_LO = 0;
    localparam int SPIH_BR_PRESCALE_LO = 4;
    // serial_status_byte (byte 3)
    localparam int SPIH_SR_TX_ROOM = 5;

    // transaction_control fields
    localparam int SPIH_XF_GO = 0;
    localparam int SPIH_XF_WRITE = 1;
    localparam int SPIH_XF_READ = 2;
    localparam int SPIH_XF_COUNT_LO = 3;
    localparam int SPIH_XF_COUNT_HI = 15;
    localparam int SPIH_XF_BE_LO = 16;

    // completion_flags bits
    localparam int SPIH_FL_READ_DONE = 0;
    localparam int SPIH_FL_WRITE_DONE = 1;
    localparam int SPIH_FL_PREAMBLE_DONE = 2;

    localparam int SPIH_NUM_SLAVES = 8;
    localparam int SPIH_BUF_BYTES = 1024;
    localparam logic [7:0] SPIH_READ_FILL = 8'hFF;

    typedef enum logic [2:0] {
        SPIH_ST_IDLE = 3'b000,
        SPIH_ST_SETUP = 3'b001,
        SPIH_ST_PRE = 3'b010,
        SPIH_ST_DATA = 3'b011,
        SPIH_ST_HOLD = 3'b100
    } spih_state_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [12:0] count;
        logic [3:0] byte_en;
    } spih_xfer_t;

endpackage

/* File: hw/spih_controller.sv */
// Summary of operation
// (RL1) Only ever acts as the single master; no arbitration or other-master detection.
// (RL2) Eight separate active-low slave select outputs, driven by the master.
// (RL3) Serial clock never faster than half the system clock.
// (RL4) Separate 1024-byte transmit and receive buffers hold post-preamble data.
// (RL5) Up to four preamble bytes (opcode, address) precede buffered data.
// (RL6) Processor moves buffer data 32 bits per access; serial side shifts bytes.
// (RL7) Write-complete flag rises when the transmit buffer becomes empty.
// (RL8) Read-complete flag rises when received bytes reach the programmed count.
// (RL9) Registers decoded at offsets 0x00 to 0x1C from the chip-select base.
// (RL10) Transfer register: go, write, read, byte count [15:3], four preamble enables.
// (RL11) Software writes control bytes only while no transaction runs.
// (RL12) Control bit 0 picks LSB-first; data always keeps MSB at bit 7.
// (RL13) Phase bit 2: first edge at byte start when 1, half cycle later when 0.
// (RL14) Polarity bit 3: clock idles high when 1, low when 0.
// (RL15) Role bit 4: master when 1, slave when 0; resets to 0. No slave logic here: with 0 a go write is ignored.
// (RL16) Enable bit 6 gives the pins to the controller; 0 disables it.
// (RL17) Interrupt enable bit 7 lets set flags assert the interrupt output.
// (RL18) Control bits 1 and 5 ignore writes and read zero.
// (RL19) Pin-control bit 8 with role bit selects single shared data line.
// (RL20) Bit 10 with role bit enables shared line output in bidirectional mode.
// (RL21) Slave select register at 0x14: one bit per slave, selects it.
// (RL22) Two 8-Kbit buffers, filled via write port and drained via read port.
// (RL23) Flag register read-only: bit 0 read, bit 1 write, bit 2 preamble done.
// (RL24) Software sets role, pin-control and output-enable per normal or bidirectional mode.
// (RL25) Clock divisor equals (prescale+1) times two to the (power+1).
// (RL26) Writing go=1 starts a transaction, go=0 stops it; direction bits pick data phase.
// (RL27) Selected slave select held low from before first bit until after last.
// (RL28) Enabled preamble bytes go out in enable order, then the data bytes.
`timescale 1ns/10ps
`default_nettype none

module spih_controller import spih_pkg::*; #(
    parameter int BUF_BYTES = SPIH_BUF_BYTES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_cs_n,
    input wire logic [2:0] i_addr,
    input wire logic i_rd_nwr,
    input wire logic [3:0] i_be_n,
    input wire logic [31:0] i_data,
    output logic [31:0] o_data,
    output logic o_data_oe,
    output logic o_ready,
    output logic o_irq,
    output logic o_sck,
    output logic o_sck_oe,
    output logic [SPIH_NUM_SLAVES-1:0] o_ss_n,
    output logic o_ss_oe,
    input wire logic i_mosi,
    output logic o_mosi,
    output logic o_mosi_oe,
    input wire logic i_miso
);

    localparam int WORDS = BUF_BYTES / 4;
    localparam int WAW = $clog2(WORDS);
    localparam int BAW = $clog2(BUF_BYTES);

    if (BUF_BYTES < 8 || (1 << BAW) != BUF_BYTES) begin : g_bad_buf
        $error("BUF_BYTES must be a power of two of at least 8");
    end

    // half serial period in system cycles; at least one, so sck <= clk/2
    function automatic logic [10:0] spih_half(input logic [2:0] pre, input logic [2:0] pow);
        spih_half = 11'({8'h00, pre} + 11'h001) << pow; // see RL25 see RL3
    endfunction

    // one shift step; the received bit enters at the end opposite the one leaving
    function automatic logic [7:0] spih_shift(input logic [7:0] sh, input logic bit_in, input logic lsbf);
        spih_shift = lsbf ? {bit_in, sh[7:1]} : {sh[6:0], bit_in}; // see RL12
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    logic cs_seen_q;
    logic acc, wr_acc, rd_acc;
    logic [4:0] off;
    logic [3:0] be;
    logic [7:0] cr1_q, cr2_q, br_q;
    logic [31:0] preamble_q;
    logic [7:0] select_q;
    logic [2:0] flags_q;
    spih_xfer_t xfer_q;
    logic start_req, stop_req;

    assign acc = !i_cs_n && !cs_seen_q;
    assign wr_acc = acc && !i_rd_nwr;
    assign rd_acc = acc && i_rd_nwr;
    assign off = {i_addr, 2'b00};
    assign be = ~i_be_n;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cs_seen_q <= 1'b0;
        end else begin
            cs_seen_q <= !i_cs_n;
        end
    end

    // control bytes honour their byte enables and keep unimplemented bits at zero
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cr1_q <= SPIH_CR1_RESET;
            cr2_q <= SPIH_CR2_RESET;
            br_q <= SPIH_BR_RESET;
        end else if (wr_acc && off == SPIH_OFF_CFG) begin // see RL9
            if (be[0]) begin
                cr1_q <= i_data[7:0] & SPIH_CR1_MASK; // see RL18
            end
            if (be[1]) begin
                cr2_q <= i_data[15:8] & SPIH_CR2_MASK;
            end
            if (be[2]) begin
                br_q <= i_data[23:16] & SPIH_BR_MASK;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            preamble_q <= 32'h0000_0000;
        end else if (wr_acc && off == SPIH_OFF_PREAMBLE) begin
            for (int i = 0; i < 4; i++) begin
                if (be[i]) begin
                    preamble_q[8*i +: 8] <= i_data[8*i +: 8];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            select_q <= 8'h00;
        end else if (wr_acc && off == SPIH_OFF_SELECT) begin
            select_q <= i_data[7:0]; // see RL21
        end
    end

    assign start_req = wr_acc && off == SPIH_OFF_XFER && i_data[SPIH_XF_GO];
    assign stop_req = wr_acc && off == SPIH_OFF_XFER && !i_data[SPIH_XF_GO];

    wire logic cfg_lsbf = cr1_q[SPIH_CR1_LOW_BIT_FIRST];
    wire logic cfg_phase = cr1_q[SPIH_CR1_PHASE];
    wire logic cfg_pol = cr1_q[SPIH_CR1_POLARITY];
    wire logic cfg_master = cr1_q[SPIH_CR1_MASTER_ROLE];
    wire logic cfg_enable = cr1_q[SPIH_CR1_PORT_ENABLE];
    wire logic cfg_ie = cr1_q[SPIH_CR1_IRQ_ENABLE];
    wire logic cfg_bidir = cr2_q[SPIH_CR2_PIN_CONFIG] && cfg_master; // see RL19
    wire logic cfg_shared_oe = cr2_q[SPIH_CR2_SHARED_OE] && cfg_master; // see RL20

    ////////////////////////////////////////////////////////////////////////////
    // buffers: word-wide on the bus side, byte-wide on the serial side

    logic [31:0] tx_mem [WORDS]; // see RL4 see RL22
    logic [31:0] rx_mem [WORDS];
    logic [WAW:0] tx_wp_q, rx_wp_q, rx_rp_q;
    logic [BAW:0] tx_rp_q, tx_level;
    logic [WAW:0] rx_words;
    logic tx_empty, tx_full, rx_full, rx_avail;
    logic tx_push, tx_pop, rx_pop, rx_push;
    logic [31:0] tx_word;
    logic [7:0] tx_byte;
    logic [31:0] rx_word_d;

    assign tx_level = {tx_wp_q, 2'b00} - tx_rp_q;
    assign tx_empty = tx_level == '0;
    assign tx_full = tx_level > (BAW+1)'(BUF_BYTES - 4);
    assign rx_words = rx_wp_q - rx_rp_q;
    assign rx_full = rx_words == (WAW+1)'(WORDS);
    assign rx_avail = rx_words != '0;
    assign tx_push = wr_acc && off == SPIH_OFF_TXPORT && !tx_full; // see RL6
    assign rx_pop = rd_acc && off == SPIH_OFF_RXPORT && rx_avail;
    assign tx_word = tx_mem[tx_rp_q[BAW-1:2]];
    assign tx_byte = 8'(tx_word >> {tx_rp_q[1:0], 3'b000});

    always_ff @(posedge i_clk) begin
        if (tx_push) begin
            tx_mem[tx_wp_q[WAW-1:0]] <= i_data;
        end
        if (rx_push) begin
            rx_mem[rx_wp_q[WAW-1:0]] <= rx_word_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            rx_wp_q <= '0;
            rx_rp_q <= '0;
        end else begin
            if (tx_push) begin
                tx_wp_q <= tx_wp_q + 1'b1;
            end
            if (tx_pop) begin
                tx_rp_q <= tx_rp_q + 1'b1;
            end
            if (rx_push) begin
                rx_wp_q <= rx_wp_q + 1'b1;
            end
            if (rx_pop) begin
                rx_rp_q <= rx_rp_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial clock divider: one-cycle pulse per half serial period

    spih_state_t state_q;
    logic [10:0] div_q;
    logic tick;

    assign tick = state_q != SPIH_ST_IDLE && div_q == 11'h000;

    always_ff @(posedge i_clk) begin
        if (i_reset || state_q == SPIH_ST_IDLE || tick) begin
            div_q <= spih_half(br_q[SPIH_BR_PRESCALE_LO +: 3], br_q[SPIH_BR_POWER_LO +: 3]) - 11'h001;
        end else begin
            div_q <= div_q - 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transaction sequencer and byte shifter

    logic [4:0] step_q;
    logic [4:0] edge_idx;
    logic in_byte, byte_edge, last_step, byte_done;
    logic [7:0] sh_q, sh_next;
    logic bit_in_q, sck_tog_q, mosi_q;
    logic [3:0] be_left_q;
    logic [12:0] data_left_q, rx_got_q;
    logic [31:0] rx_acc_q;
    logic [1:0] rx_bi_q;
    logic data_ok, want_next, load_pre, load_data;
    logic [1:0] pre_idx;
    logic serial_in;

    assign in_byte = state_q == SPIH_ST_PRE || state_q == SPIH_ST_DATA;
    // with phase 0 the first edge lands one half period into the byte
    assign edge_idx = cfg_phase ? step_q : step_q - 5'd1; // see RL13
    assign byte_edge = in_byte && tick && (cfg_phase || step_q != 5'd0);
    assign last_step = edge_idx == 5'd15;
    assign byte_done = byte_edge && last_step;
    assign sh_next = spih_shift(sh_q, bit_in_q, cfg_lsbf);
    // shared line replaces the receive line in bidirectional mode
    assign serial_in = cfg_bidir ? i_mosi : i_miso; // see RL19

    always_comb begin
        pre_idx = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (be_left_q[i]) begin
                pre_idx = 2'(i);
            end
        end
    end

    // a data byte waits (clock parked) until the buffers can serve it
    assign data_ok = data_left_q > 13'(byte_done && state_q == SPIH_ST_DATA) &&
                     (!xfer_q.write || !tx_empty) && (!xfer_q.read || !rx_full); // see RL28
    assign want_next = (state_q == SPIH_ST_SETUP && tick) || byte_done ||
                       (state_q == SPIH_ST_DATA && step_q == 5'd31);
    assign load_pre = want_next && be_left_q != 4'h0; // see RL28
    assign load_data = want_next && be_left_q == 4'h0 && data_ok;
    assign tx_pop = load_data && xfer_q.write;
    assign rx_word_d = rx_acc_q | (32'(sh_next) << {rx_bi_q, 3'b000});
    assign rx_push = byte_done && state_q == SPIH_ST_DATA && xfer_q.read &&
                     (rx_bi_q == 2'd3 || data_left_q == 13'd1);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= SPIH_ST_IDLE;
            xfer_q <= '0;
            be_left_q <= 4'h0;
            data_left_q <= '0;
        end else if (stop_req && state_q != SPIH_ST_IDLE) begin
            state_q <= SPIH_ST_HOLD; // see RL26
        end else begin
            case (state_q)
                SPIH_ST_IDLE: begin
                    // no slave role and no other master exist here
                    if (start_req && cfg_master && cfg_enable) begin // see RL1 see RL15 see RL16 see RL26
                        state_q <= SPIH_ST_SETUP;
                        xfer_q.write <= i_data[SPIH_XF_WRITE]; // see RL10
                        xfer_q.read <= i_data[SPIH_XF_READ];
                        xfer_q.count <= i_data[SPIH_XF_COUNT_HI:SPIH_XF_COUNT_LO];
                        xfer_q.byte_en <= i_data[SPIH_XF_BE_LO +: 4];
                        be_left_q <= i_data[SPIH_XF_BE_LO +: 4]; // see RL5
                        data_left_q <= i_data[SPIH_XF_COUNT_HI:SPIH_XF_COUNT_LO];
                    end
                end
                SPIH_ST_SETUP, SPIH_ST_PRE, SPIH_ST_DATA: begin
                    if (byte_done && state_q == SPIH_ST_DATA) begin
                        data_left_q <= data_left_q - 13'd1;
                    end
                    if (load_pre) begin
                        state_q <= SPIH_ST_PRE;
                        be_left_q[pre_idx] <= 1'b0;
                    end else if (load_data) begin
                        state_q <= SPIH_ST_DATA;
                    end else if (want_next) begin
                        // remaining count but buffers not ready: wait parked in data
                        state_q <= (data_left_q > 13'(byte_done && state_q == SPIH_ST_DATA)) ?
                                   SPIH_ST_DATA : SPIH_ST_HOLD;
                    end
                end
                SPIH_ST_HOLD: begin
                    if (tick) begin
                        state_q <= SPIH_ST_IDLE;
                    end
                end
                default: state_q <= SPIH_ST_IDLE;
            endcase
        end
    end

    // step 31 marks a byte slot that is parked waiting for buffer space or data
    always_ff @(posedge i_clk) begin
        if (i_reset || !in_byte) begin
            step_q <= 5'd0;
        end else if (load_pre || load_data) begin
            step_q <= 5'd0;
        end else if (want_next) begin
            step_q <= 5'd31;
        end else if (tick && step_q != 5'd31) begin
            step_q <= step_q + 5'd1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || state_q == SPIH_ST_IDLE || state_q == SPIH_ST_HOLD) begin
            sh_q <= 8'h00;
            bit_in_q <= 1'b0;
            sck_tog_q <= 1'b0;
            mosi_q <= 1'b0;
        end else if (load_pre || load_data) begin
            sh_q <= load_pre ? preamble_q[8*pre_idx +: 8] : (xfer_q.write ? tx_byte : SPIH_READ_FILL);
            mosi_q <= cfg_lsbf ? (load_pre ? preamble_q[8*pre_idx] : (xfer_q.write ? tx_byte[0] : 1'b1))
                               : (load_pre ? preamble_q[8*pre_idx+7] : (xfer_q.write ? tx_byte[7] : 1'b1));
            sck_tog_q <= 1'b0;
        end else if (byte_edge && step_q != 5'd31) begin
            sck_tog_q <= !sck_tog_q;
            if (!edge_idx[0]) begin
                bit_in_q <= serial_in;
            end else begin
                sh_q <= sh_next;
                mosi_q <= cfg_lsbf ? sh_next[0] : sh_next[7]; // see RL12
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || state_q == SPIH_ST_IDLE) begin
            rx_acc_q <= 32'h0000_0000;
            rx_bi_q <= 2'd0;
            rx_got_q <= '0;
        end else if (byte_done && state_q == SPIH_ST_DATA && xfer_q.read) begin
            rx_acc_q <= rx_push ? 32'h0000_0000 : rx_word_d;
            rx_bi_q <= rx_bi_q + 2'd1;
            rx_got_q <= rx_got_q + 13'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // completion flags: cleared by reading them, a coincident event wins

    logic [2:0] flag_set;

    always_comb begin
        flag_set = 3'b000;
        flag_set[SPIH_FL_READ_DONE] = byte_done && state_q == SPIH_ST_DATA && xfer_q.read &&
                                      rx_got_q + 13'd1 == xfer_q.count; // see RL8
        flag_set[SPIH_FL_WRITE_DONE] = tx_pop && tx_level == (BAW+1)'(1); // see RL7
        flag_set[SPIH_FL_PREAMBLE_DONE] = byte_done && state_q == SPIH_ST_PRE && be_left_q == 4'h0;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            flags_q <= 3'b000;
        end else if (rd_acc && off == SPIH_OFF_FLAGS) begin
            flags_q <= flag_set; // see RL23
        end else begin
            flags_q <= flags_q | flag_set;
        end
    end

    assign o_irq = cfg_ie && (flags_q != 3'b000); // see RL17

    ////////////////////////////////////////////////////////////////////////////
    // read data and ready

    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (off)
            SPIH_OFF_CFG: rd_word = {2'b00, !tx_full, 5'b00000, br_q, cr2_q, cr1_q};
            SPIH_OFF_FLAGS: rd_word = {29'h0000_0000, flags_q};
            SPIH_OFF_RXPORT: rd_word = rx_avail ? rx_mem[rx_rp_q[WAW-1:0]] : 32'h0000_0000;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_data <= 32'h0000_0000;
            o_ready <= 1'b0;
        end else begin
            o_ready <= acc;
            if (rd_acc) begin
                o_data <= rd_word;
            end
        end
    end

    assign o_data_oe = !i_cs_n && i_rd_nwr;

    ////////////////////////////////////////////////////////////////////////////
    // serial pins

    logic frame;

    assign frame = state_q != SPIH_ST_IDLE;
    assign o_sck = cfg_pol ^ sck_tog_q; // see RL14
    assign o_sck_oe = cfg_enable;
    assign o_ss_n = ~(select_q & {SPIH_NUM_SLAVES{frame}}); // see RL2 see RL27
    assign o_ss_oe = cfg_enable;
    assign o_mosi = mosi_q;
    assign o_mosi_oe = cfg_enable && (!cfg_bidir || cfg_shared_oe); // see RL20

endmodule

`default_nettype wire

/* File: verif/spih_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module spih_assertions import spih_pkg::*; (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_cs_n,
    input wire logic [2:0] i_addr,
    input wire logic i_rd_nwr,
    input wire logic [31:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_ready,
    input wire logic o_irq,
    input wire logic o_sck,
    input wire logic o_sck_oe,
    input wire logic [SPIH_NUM_SLAVES-1:0] o_ss_n,
    input wire logic o_ss_oe,
    input wire logic o_mosi_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic frame;
    assign frame = o_ss_n != 8'hFF;
    ////////////////////////////////////////////////////////////////
    chk_ready_pulse: assert property ($fell(i_cs_n) |=> o_ready ##1 !o_ready)
        else $error("ready not a single pulse after access");
    chk_read_drive: assert property (o_data_oe == (!i_cs_n && i_rd_nwr))
        else $error("read drive enable wrong");
    chk_data_hold: assert property ($changed(o_data) |-> o_ready)
        else $error("read data moved outside an answer");
    chk_wo_read_zero: assert property (($fell(i_cs_n) && i_rd_nwr && i_addr inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6})
        |=> o_data == 32'h0)
        else $error("write-only or reserved read not zero");
    chk_oe_tied: assert property (o_ss_oe == o_sck_oe)
        else $error("select and clock enables differ");
    chk_disabled_quiet: assert property (!o_sck_oe |-> !o_mosi_oe && o_ss_n == 8'hFF)
        else $error("disabled port still active");
    chk_select_setup: assert property (frame && $past(o_ss_n) == 8'hFF |-> $stable(o_sck))
        else $error("clock moved as select fell");
    chk_sck_in_frame: assert property ($changed(o_sck) |-> frame || $past(frame) || o_ready)
        else $error("clock moved outside a frame");
    cover property ($fell(frame));
    cover property (o_irq);
    cover property ($fell(i_cs_n) && i_rd_nwr && i_addr == 3'h7);
endmodule
bind spih_controller spih_assertions spih_assertions_i(.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n),
    .i_addr(i_addr), .i_rd_nwr(i_rd_nwr), .o_data(o_data), .o_data_oe(o_data_oe), .o_ready(o_ready),
    .o_irq(o_irq), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_ss_n(o_ss_n), .o_ss_oe(o_ss_oe),
    .o_mosi_oe(o_mosi_oe));
`default_nettype wire

/* File: verif/spih_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spih_slave_model (
    input wire logic i_sck,
    input wire logic i_sel_n,
    input wire logic i_mosi,
    input wire logic i_cpol,
    input wire logic i_lsb,
    input wire logic [7:0] i_reply,
    output logic o_miso
);
    logic [7:0] rx = 8'h00;
    int n = 0;
    logic [7:0] got[$];
    initial o_miso = 1'b0;
    always @(negedge i_sel_n) begin
        n = 0;
        got.delete();
        o_miso = i_lsb ? i_reply[0] : i_reply[7];
    end
    // a released line must not keep looking valid
    always @(posedge i_sel_n) o_miso = ~o_miso;
    always @(i_sck) begin
        if (!i_sel_n && i_sck != i_cpol) begin
            rx = i_lsb ? {i_mosi, rx[7:1]} : {rx[6:0], i_mosi};
            n = n + 1;
            if (n % 8 == 0) got.push_back(rx);
        end else if (!i_sel_n) begin
            o_miso = i_lsb ? i_reply[n % 8] : i_reply[7 - n % 8];
        end
    end
endmodule
`default_nettype wire

/* File: verif/spih_controller_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module spih_controller_tb import spih_pkg::*;;
    logic i_clk = 1'b0, i_reset = 1'b1, i_cs_n = 1'b1, i_rd_nwr = 1'b0, i_mosi, miso;
    logic [2:0] i_addr = 3'h0;
    logic [3:0] i_be_n = 4'hF, be;
    logic [31:0] i_data = 32'h0, o_data, rd, cfg, pre, tx;
    logic o_data_oe, o_ready, o_irq, o_sck, o_sck_oe, o_ss_oe, o_mosi, o_mosi_oe, sck_q = 1'b0;
    logic [7:0] o_ss_n, ss_seen = 8'hFF, sel, reply = 8'h00;
    int failures = 0, tests_run = 0, cyc = 0, chg = 0, gap = 0;
    logic [7:0] exp_q[$];
    always #10 i_clk = ~i_clk;
    assign i_mosi = o_mosi_oe ? o_mosi : ~o_mosi;
    spih_controller #(.BUF_BYTES(16)) spih_controller_i(.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n),
        .i_addr(i_addr), .i_rd_nwr(i_rd_nwr), .i_be_n(i_be_n), .i_data(i_data), .o_data(o_data),
        .o_data_oe(o_data_oe), .o_ready(o_ready), .o_irq(o_irq), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
        .o_ss_n(o_ss_n), .o_ss_oe(o_ss_oe), .i_mosi(i_mosi), .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe),
        .i_miso(miso));
    spih_slave_model spih_slave_model_i(.i_sck(o_sck), .i_sel_n(&o_ss_n), .i_mosi(i_mosi), .i_cpol(cfg[3]),
        .i_lsb(cfg[0]), .i_reply(reply), .o_miso(miso));
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one access per select-low period; held until ready is seen high
    task automatic acc(input logic r, input logic [4:0] off, input logic [31:0] d);
        int k;
        @(negedge i_clk);
        i_cs_n = 1'b0;
        i_rd_nwr = r;
        i_addr = off[4:2];
        i_data = d;
        i_be_n = 4'h0;
        for (k = 0; k < 8 && o_ready !== 1'b1; k++) @(negedge i_clk);
        if (o_ready !== 1'b1) failures++;
        rd = o_data;
        @(negedge i_clk);
        i_cs_n = 1'b1;
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 5000 && o_ss_n !== 8'hFF; k++) @(negedge i_clk);
        if (o_ss_n !== 8'hFF) failures++;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        sck_q <= o_sck;
        if (o_ss_n != 8'hFF) ss_seen <= o_ss_n;
        if (o_sck != sck_q && o_ss_n != 8'hFF) begin
            gap <= cyc - chg;
            chg <= cyc;
        end
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'h0f8e));
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        acc(1'b1, SPIH_OFF_CFG, 32'h0);
        chk("cfg reset", 32'h20000004, rd);
        acc(1'b0, SPIH_OFF_CFG, 32'hFFFFFFFF);
        acc(1'b1, SPIH_OFF_CFG, 32'h0);
        chk("cfg mask", 32'h207705DD, rd);
        chk("sck idle high", 32'h1, {31'h0, o_sck});
        chk("shared oe", 32'h1, {31'h0, o_mosi_oe});
        for (int a = 1; a < 7; a++) begin
            if (a != 4) acc(1'b1, 5'(a * 4), 32'h0);
            if (a != 4) chk("wo read", 32'h0, rd);
        end
        for (int m = 0; m < 4; m++) begin
            // normal master mode: pin-control and shared-line enable stay 0
            cfg = {8'h00, 1'b0, 3'(m), 1'b0, 3'(m & 1), 8'h00, 4'hD, m[1], ~m[0], 1'b0, m[0]};
            acc(1'b0, SPIH_OFF_CFG, cfg);
            pre = $urandom;
            tx = $urandom;
            sel = 8'h01 << ($urandom % 8);
            be = 4'($urandom) | 4'h1;
            acc(1'b0, SPIH_OFF_PREAMBLE, pre);
            acc(1'b0, SPIH_OFF_SELECT, {24'h0, sel});
            acc(1'b0, SPIH_OFF_TXPORT, tx);
            exp_q.delete();
            for (int b = 0; b < 4; b++) if (be[b]) exp_q.push_back(pre[8*b +: 8]);
            for (int b = 0; b < 4; b++) exp_q.push_back(tx[8*b +: 8]);
            acc(1'b0, SPIH_OFF_XFER, {12'h0, be, 13'd4, 3'b011});
            wait_idle();
            chk("byte count", exp_q.size(), spih_slave_model_i.got.size());
            foreach (exp_q[i]) chk("serial byte", exp_q[i], spih_slave_model_i.got[i]);
            chk("sck half period", (m + 1) << (m & 1), gap);
            chk("select lines", {24'h0, ~sel}, {24'h0, ss_seen});
            chk("irq raised", 32'h1, {31'h0, o_irq});
            acc(1'b1, SPIH_OFF_FLAGS, 32'h0);
            chk("write flags", 32'h6, rd & 32'h6);
            chk("irq cleared", 32'h0, {31'h0, o_irq});
            reply = 8'($urandom);
            acc(1'b0, SPIH_OFF_XFER, {12'h0, 4'h0, 13'd4, 3'b101});
            wait_idle();
            chk("read bytes", 32'd4, spih_slave_model_i.got.size());
            chk("read fill", SPIH_READ_FILL, spih_slave_model_i.got[0]);
            acc(1'b1, SPIH_OFF_RXPORT, 32'h0);
            chk("rx word", {4{reply}}, rd);
            acc(1'b1, SPIH_OFF_FLAGS, 32'h0);
            chk("read flag", 32'h1, rd & 32'h1);
            acc(1'b1, SPIH_OFF_RXPORT, 32'h0);
            chk("rx empty", 32'h0, rd);
        end
        for (int w = 0; w < 4; w++) acc(1'b0, SPIH_OFF_TXPORT, $urandom);
        acc(1'b1, SPIH_OFF_CFG, 32'h0);
        chk("tx room", 32'h0, {31'h0, rd[SPIH_SR_TX_ROOM + 24]});
        close_out();
    end
endmodule
`default_nettype wire
